// ### shared/tft_timing_pkg.sv
// constants and carrier types shared by the tft panel timing core
package tft_timing_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int CNT_W = 11;
  localparam int NREG  = 14;
  localparam int IDX_W = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PIXEL_CLOCK      = 8'h04;
  localparam logic [7:0] OFS_SYSTEM_CONFIG    = 8'h10;
  localparam logic [7:0] OFS_TIMING_STATUS    = 8'h11;
  localparam logic [7:0] OFS_LINE_WIDTH       = 8'h14;
  localparam logic [7:0] OFS_LINE_BLANK_FINE  = 8'h15;
  localparam logic [7:0] OFS_LINE_BLANK       = 8'h16;
  localparam logic [7:0] OFS_LINE_SYNC_START  = 8'h17;
  localparam logic [7:0] OFS_LINE_SYNC_WIDTH  = 8'h18;
  localparam logic [7:0] OFS_HEIGHT_LOW       = 8'h19;
  localparam logic [7:0] OFS_HEIGHT_HIGH      = 8'h1A;
  localparam logic [7:0] OFS_FRAME_BLANK_LOW  = 8'h1B;
  localparam logic [7:0] OFS_FRAME_BLANK_HIGH = 8'h1C;
  localparam logic [7:0] OFS_FRAME_SYNC_LOW   = 8'h1D;
  localparam logic [7:0] OFS_FRAME_SYNC_HIGH  = 8'h1E;
  localparam logic [7:0] OFS_FRAME_SYNC_WIDTH = 8'h1F;

  // ----------------------------------------------------------------
  // storage index of each writable register
  // ----------------------------------------------------------------
  localparam int IDX_PCLK  = 0;
  localparam int IDX_SYS   = 1;
  localparam int IDX_HW    = 2;
  localparam int IDX_HFINE = 3;
  localparam int IDX_HBLK  = 4;
  localparam int IDX_HSTA  = 5;
  localparam int IDX_HSW   = 6;
  localparam int IDX_VH0   = 7;
  localparam int IDX_VH1   = 8;
  localparam int IDX_VB0   = 9;
  localparam int IDX_VB1   = 10;
  localparam int IDX_VS0   = 11;
  localparam int IDX_VS1   = 12;
  localparam int IDX_VSW   = 13;

  // ----------------------------------------------------------------
  // writable bit masks, reset value
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_PCLK  = 8'h83;
  localparam logic [7:0] MASK_SYS   = 8'h0F;
  localparam logic [7:0] MASK_HW    = 8'h7F;
  localparam logic [7:0] MASK_HFINE = 8'h8F;
  localparam logic [7:0] MASK_FIVE  = 8'h1F;
  localparam logic [7:0] MASK_HSW   = 8'h9F;
  localparam logic [7:0] MASK_BYTE  = 8'hFF;
  localparam logic [7:0] MASK_BIT8  = 8'h01;
  localparam logic [7:0] RST_CFG    = 8'h00;

  localparam logic [7:0] REG_OFS [NREG] = '{
    OFS_PIXEL_CLOCK, OFS_SYSTEM_CONFIG, OFS_LINE_WIDTH, OFS_LINE_BLANK_FINE,
    OFS_LINE_BLANK, OFS_LINE_SYNC_START, OFS_LINE_SYNC_WIDTH, OFS_HEIGHT_LOW,
    OFS_HEIGHT_HIGH, OFS_FRAME_BLANK_LOW, OFS_FRAME_BLANK_HIGH, OFS_FRAME_SYNC_LOW,
    OFS_FRAME_SYNC_HIGH, OFS_FRAME_SYNC_WIDTH};
  localparam logic [7:0] REG_MASK [NREG] = '{
    MASK_PCLK, MASK_SYS, MASK_HW, MASK_HFINE, MASK_FIVE, MASK_FIVE, MASK_HSW,
    MASK_BYTE, MASK_BIT8, MASK_BYTE, MASK_BIT8, MASK_BYTE, MASK_BIT8, MASK_BYTE};

  // ----------------------------------------------------------------
  // field positions and timing units
  // ----------------------------------------------------------------
  localparam int POL_BIT        = 7;
  localparam int DEPTH_HI_BIT   = 3;
  localparam int BUS_HI_BIT     = 1;
  localparam int UNIT_PIX       = 8;
  localparam logic [CNT_W-1:0] BLANK_EXTRA = 11'h002;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic [CNT_W-1:0] active;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] sync_begin;
    logic [CNT_W-1:0] sync_end;
  } axis_cfg_s;

  typedef struct packed {
    logic pclk;
    logic hsync;
    logic vsync;
    logic de;
  } panel_s;

endpackage

// ### core/pixel_clock_gen.sv
// pixel clock divider: pixel tick and pixel clock pin
`timescale 1ns/1ps
`default_nettype none
module pixel_clock_gen (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // setting
  input  wire logic [1:0] div_code,
  input  wire logic       invert,
  // outputs
  output logic            tick,
  output logic            pclk
);
  import tft_timing_pkg::*;

  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       pclk_reg;
  logic       pclk_next;
  logic [2:0] last_val;
  logic [2:0] half;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // >= so a shorter period set mid-count recovers at once
  always_comb begin
    last_val  = 3'((4'h1 << div_code) - 4'h1);
    half      = 3'((4'h1 << div_code) >> 1);
    tick      = (cnt_reg >= last_val);
    cnt_next  = tick ? 3'h0 : 3'(cnt_reg + 3'h1);
    pclk_next = (cnt_next >= half) ^ invert;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg  <= 3'h0;
      pclk_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      pclk_reg <= pclk_next;
    end
  end

  assign pclk = pclk_reg;
endmodule
`default_nettype wire

// ### core/timing_axis.sv
// one timing axis: position counter, active window, sync window
`timescale 1ns/1ps
`default_nettype none
module timing_axis (
  // clock and reset
  input  wire logic                                mclk,
  input  wire logic                                rst,
  // advance and setting
  input  wire logic                                step,
  input  wire tft_timing_pkg::axis_cfg_s           cfg,
  // state
  output logic [tft_timing_pkg::CNT_W-1:0]         cnt,
  output logic                                     in_active,
  output logic                                     in_sync,
  output logic                                     last
);
  import tft_timing_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // ----------------------------------------------------------------
  // position decode
  // ----------------------------------------------------------------
  // >= so a total shrunk by software still wraps
  always_comb begin
    last      = (cnt_reg >= CNT_W'(cfg.total - 11'h001));
    in_active = (cnt_reg < cfg.active);
    in_sync   = (cnt_reg >= cfg.sync_begin) && (cnt_reg < cfg.sync_end);
    cnt_next  = cnt_reg;
    if (step) begin
      cnt_next = last ? '0 : CNT_W'(cnt_reg + 11'h001);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cnt = cnt_reg;
endmodule
`default_nettype wire

// ### core/tft_panel_timing_config.sv
// tft panel configuration registers and sync/enable timing generator
//
// What this block does
// - depth 00b is 8 bpp, 1x is 16
// - bus width 00b is 8 bit, 1x 16
// - active width is (field+1) times 8 pixels
// - enable polarity bit 0 high, 1 low
// - line blanking is (coarse+1)*8 + fine + 2
// - line sync starts (field+1)*8 after active
// - line sync polarity bit 0 low, 1 high
// - line sync lasts (field+1)*8 pixels
// - frame height is nine-bit value plus one
// - pixel clock divides by 1,2,4,8, pin parked when undivided; invertible
// - frame blanking is nine-bit value plus one
// - frame sync starts value+1 lines after active
// - frame sync lasts value+1 lines, polarity bit
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tft_panel_timing_config (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // register port
  input  wire tft_timing_pkg::reg_req_s   bus,
  output logic [7:0]                      rdata,
  // panel pins
  output tft_timing_pkg::panel_s          panel,
  // system configuration
  output logic                            pixel_16bpp,
  output logic                            host_bus_16
);
  import tft_timing_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]       cfg_reg [NREG];
  logic [7:0]       cfg_next [NREG];
  logic [7:0]       rdata_reg;
  logic [7:0]       rdata_next;
  logic             hsync_reg;
  logic             hsync_next;
  logic             vsync_reg;
  logic             vsync_next;
  logic             de_reg;
  logic             de_next;
  logic             hit;
  logic [IDX_W-1:0] idx;
  logic             tick;
  logic             pclk_pin;
  axis_cfg_s        h_cfg;
  axis_cfg_s        v_cfg;
  logic [CNT_W-1:0] h_cnt;
  logic [CNT_W-1:0] v_cnt;
  logic             h_act;
  logic             v_act;
  logic             h_sync;
  logic             v_sync;
  logic             h_last;
  logic             v_last;
  logic [7:0]       status;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address to storage index; bit IDX_W is the hit flag
  function automatic logic [IDX_W:0] reg_lookup(input logic [7:0] a);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < NREG; i++) begin
      if (a == REG_OFS[i]) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // field plus one, in 8-pixel units
  function automatic logic [CNT_W-1:0] in_units(input logic [6:0] v);
    return CNT_W'((CNT_W'(v) + 11'h001) * UNIT_PIX);
  endfunction

  // nine-bit line value plus one
  function automatic logic [CNT_W-1:0] in_lines(input logic hi, input logic [7:0] lo);
    return CNT_W'({hi, lo}) + 11'h001;
  endfunction

  assign {hit, idx} = reg_lookup(bus.addr);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // masking at write time keeps reserved bits zero for every read
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (bus.wr && hit) begin
      cfg_next[idx] = bus.wdata & REG_MASK[idx];
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NREG; i++) begin
      if (rst) begin
        cfg_reg[i] <= RST_CFG;
      end else begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // live position for software polling
  assign status = {4'h0, v_sync, h_sync, !v_act, h_act && v_act};

  // read data stand for one cycle only, zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (bus.rd) begin
      if (hit) begin
        rdata_next = cfg_reg[idx];
      end else if (bus.addr == OFS_TIMING_STATUS) begin
        rdata_next = status;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata       = rdata_reg;
  assign pixel_16bpp = cfg_reg[IDX_SYS][DEPTH_HI_BIT];
  assign host_bus_16 = cfg_reg[IDX_SYS][BUS_HI_BIT];

  // ----------------------------------------------------------------
  // derived geometry
  // ----------------------------------------------------------------
  // no range checks: oversized settings just give a long frame
  always_comb begin
    h_cfg.active     = in_units(cfg_reg[IDX_HW][6:0]);
    h_cfg.total      = CNT_W'(h_cfg.active + in_units({2'b00, cfg_reg[IDX_HBLK][4:0]})
                       + CNT_W'(cfg_reg[IDX_HFINE][3:0]) + BLANK_EXTRA);
    h_cfg.sync_begin = CNT_W'(h_cfg.active
                       + in_units({2'b00, cfg_reg[IDX_HSTA][4:0]}));
    h_cfg.sync_end   = CNT_W'(h_cfg.sync_begin
                       + in_units({2'b00, cfg_reg[IDX_HSW][4:0]}));
    v_cfg.active     = in_lines(cfg_reg[IDX_VH1][0], cfg_reg[IDX_VH0]);
    v_cfg.total      = CNT_W'(v_cfg.active
                       + in_lines(cfg_reg[IDX_VB1][0], cfg_reg[IDX_VB0]));
    v_cfg.sync_begin = CNT_W'(v_cfg.active
                       + in_lines(cfg_reg[IDX_VS1][0], cfg_reg[IDX_VS0]));
    v_cfg.sync_end   = CNT_W'(v_cfg.sync_begin
                       + in_lines(1'b0, {1'b0, cfg_reg[IDX_VSW][6:0]}));
  end

  // ----------------------------------------------------------------
  // pixel clock and counters
  // ----------------------------------------------------------------
  pixel_clock_gen u_pclk (
    .mclk     (mclk),
    .rst      (rst),
    .div_code (cfg_reg[IDX_PCLK][1:0]),
    .invert   (cfg_reg[IDX_PCLK][POL_BIT]),
    .tick     (tick),
    .pclk     (pclk_pin)
  );

  timing_axis u_line (
    .mclk      (mclk),
    .rst       (rst),
    .step      (tick),
    .cfg       (h_cfg),
    .cnt       (h_cnt),
    .in_active (h_act),
    .in_sync   (h_sync),
    .last      (h_last)
  );

  // frame axis advances once per finished line
  timing_axis u_frame (
    .mclk      (mclk),
    .rst       (rst),
    .step      (tick && h_last),
    .cfg       (v_cfg),
    .cnt       (v_cnt),
    .in_active (v_act),
    .in_sync   (v_sync),
    .last      (v_last)
  );

  // ----------------------------------------------------------------
  // panel outputs
  // ----------------------------------------------------------------
  // sampled on the pixel tick so pins move with the pixel clock edge
  always_comb begin
    hsync_next = hsync_reg;
    vsync_next = vsync_reg;
    de_next    = de_reg;
    if (tick) begin
      hsync_next = cfg_reg[IDX_HSW][POL_BIT] ? h_sync : !h_sync;
      vsync_next = cfg_reg[IDX_VSW][POL_BIT] ? v_sync : !v_sync;
      de_next    = (h_act && v_act) ^ cfg_reg[IDX_HFINE][POL_BIT];
    end
  end

  // reset values match a zeroed register file: syncs idle high
  always_ff @(posedge mclk) begin
    if (rst) begin
      hsync_reg <= 1'b1;
      vsync_reg <= 1'b1;
      de_reg    <= 1'b0;
    end else begin
      hsync_reg <= hsync_next;
      vsync_reg <= vsync_next;
      de_reg    <= de_next;
    end
  end

  assign panel = '{pclk: pclk_pin, hsync: hsync_reg, vsync: vsync_reg, de: de_reg};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_depth_select: assert property (bus.wr && bus.addr == OFS_SYSTEM_CONFIG
    |=> pixel_16bpp == $past(bus.wdata[DEPTH_HI_BIT])) else $error("depth select wrong");
  a_bus_width: assert property (bus.wr && bus.addr == OFS_SYSTEM_CONFIG
    |=> host_bus_16 == $past(bus.wdata[BUS_HI_BIT])) else $error("bus width wrong");
  a_line_width: assert property (bus.wr && bus.addr == OFS_LINE_WIDTH
    |=> h_cfg.active == CNT_W'(($past(bus.wdata[6:0]) + 11'h001) * 8))
    else $error("active width wrong");
  a_enable_polarity: assert property (tick && !v_act
    |=> panel.de == $past(cfg_reg[IDX_HFINE][POL_BIT])) else $error("enable polarity wrong");
  a_fine_step: assert property (bus.wr && bus.addr == OFS_LINE_BLANK_FINE
    && $stable(h_cfg.active) |=> h_cfg.total == CNT_W'($past(h_cfg.total)
    - $past(cfg_reg[IDX_HFINE][3:0]) + $past(bus.wdata[3:0])))
    else $error("fine tuning step wrong");
  a_line_blank: assert property (h_cfg.total - h_cfg.active
    == CNT_W'((cfg_reg[IDX_HBLK][4:0] + 11'h001) * 8 + cfg_reg[IDX_HFINE][3:0] + 2))
    else $error("line blanking wrong");
  // only edges made by the counter: a settings write may move the window
  a_hsync_start: assert property ($rose(h_sync) && $stable(h_cfg)
    |-> h_cnt == CNT_W'(h_cfg.active + (cfg_reg[IDX_HSTA][4:0] + 11'h001) * 8))
    else $error("line sync start wrong");
  a_hsync_polarity: assert property (tick
    |=> panel.hsync == ($past(h_sync) ~^ $past(cfg_reg[IDX_HSW][POL_BIT])))
    else $error("line sync polarity wrong");
  a_hsync_width: assert property (h_cfg.sync_end - h_cfg.sync_begin
    == CNT_W'((cfg_reg[IDX_HSW][4:0] + 11'h001) * 8)) else $error("line sync width wrong");
  a_frame_height: assert property (v_cfg.active
    == CNT_W'({cfg_reg[IDX_VH1][0], cfg_reg[IDX_VH0]}) + 11'h001)
    else $error("frame height wrong");
  a_pclk_full: assert property (cfg_reg[IDX_PCLK][1:0] == 2'b00 |-> tick)
    else $error("undivided pixel tick missing");
  // the code must hold over both following cycles, so no write may land
  a_pclk_half: assert property (tick && cfg_reg[IDX_PCLK][1:0] == 2'b01
    && !(bus.wr && bus.addr == OFS_PIXEL_CLOCK)
    ##1 !(bus.wr && bus.addr == OFS_PIXEL_CLOCK) |-> !tick ##1 tick)
    else $error("pixel clock half rate wrong");
  a_frame_blank: assert property (v_cfg.total - v_cfg.active
    == CNT_W'({cfg_reg[IDX_VB1][0], cfg_reg[IDX_VB0]}) + 11'h001)
    else $error("frame blanking wrong");
  a_vsync_start: assert property ($rose(v_sync) && $stable(v_cfg) |-> v_cnt
    == CNT_W'(v_cfg.active + {cfg_reg[IDX_VS1][0], cfg_reg[IDX_VS0]} + 11'h001))
    else $error("frame sync start wrong");
  a_vsync_width: assert property (v_cfg.sync_end - v_cfg.sync_begin
    == CNT_W'(cfg_reg[IDX_VSW][6:0]) + 11'h001) else $error("frame sync width wrong");
  a_enable_active: assert property (tick && h_act && v_act
    |=> panel.de != $past(cfg_reg[IDX_HFINE][POL_BIT])) else $error("enable missing");
  a_unmapped_zero: assert property (bus.rd && !hit && bus.addr != OFS_TIMING_STATUS
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_reserved_zero: assert property (bus.rd && bus.addr == OFS_LINE_WIDTH
    |=> rdata[7] == 1'b0) else $error("reserved bit reads one");

  c_enable_rise: cover property (tick && h_act && v_act ##1 panel.de);
  c_frame_wrap: cover property (tick && h_last && v_last);
  c_write_read: cover property (bus.wr && hit ##1 bus.rd && hit);
  c_vsync_seen: cover property ($rose(v_sync));
endmodule
`default_nettype wire

// ### tb/panel_model.sv
// panel model: samples the panel pins and measures line and frame timing
`timescale 1ns/1ps
`default_nettype none
module panel_model (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // pins and the levels the panel expects
  input  wire tft_timing_pkg::panel_s panel,
  input  wire logic                   inv,
  input  wire logic                   pol,
  // measurements, in mclk cycles or pixels
  output logic [15:0]                 clk_per,
  output logic [15:0]                 line_len,
  output logic [15:0]                 de_len,
  output logic [15:0]                 hs_start,
  output logic [15:0]                 hs_len,
  output logic [15:0]                 vs_start,
  output logic [15:0]                 vs_len,
  output logic [15:0]                 frame_len,
  output logic [15:0]                 act_lines
);
  import tft_timing_pkg::*;
  logic        pclk_q, de_q, hs_q, vs_q, smp, de_a, hs_a, vs_a, hs_ok;
  logic [15:0] mcnt, pix, fcnt, de_cnt, hs_cnt, vs_cnt, lines;
  // active levels as the panel sees them
  assign de_a = panel.de ^ pol;
  assign hs_a = panel.hsync ~^ pol;
  assign vs_a = panel.vsync ~^ pol;
  // sample on the edge the inversion bit selects, mid-pixel so data is settled
  assign smp  = (panel.pclk != pclk_q) && (panel.pclk != inv);
  // counters restart on leading edges; pulse lengths latch on trailing edges, line and frame lengths on leading edges
  always @(posedge mclk) begin
    pclk_q <= rst ? 1'h0 : panel.pclk;
    mcnt   <= rst ? 16'h0000 : mcnt + 16'h0001;
    // measuring state starts known; without this it would stay unknown
    if (rst) begin
      {de_q, hs_q, vs_q, hs_ok} <= 4'h0;
      {pix, fcnt, lines}        <= 48'h0;
      {de_cnt, hs_cnt, vs_cnt}  <= 48'h0;
    end else if (smp) begin
      mcnt    <= 16'h0001;
      clk_per <= mcnt;
      de_q    <= de_a;
      hs_q    <= hs_a;
      vs_q    <= vs_a;
      pix     <= pix + 16'h0001;
      fcnt    <= fcnt + 16'h0001;
      de_cnt  <= de_a ? de_cnt + 16'h0001 : 16'h0000;
      hs_cnt  <= hs_a ? hs_cnt + 16'h0001 : 16'h0000;
      vs_cnt  <= vs_a ? vs_cnt + 16'h0001 : 16'h0000;
      // first line of a frame follows blanking, so its distance is skipped
      if (de_a && !de_q) begin
        if (lines != 16'h0000) line_len <= pix;
        pix   <= 16'h0001;
        lines <= lines + 16'h0001;
        hs_ok <= 1'h1;
      end
      if (!de_a && de_q) de_len <= de_cnt;
      // blank lines have no enable edge to count from, so skip them
      if (hs_a && !hs_q) begin
        if (hs_ok) hs_start <= pix;
        hs_ok <= 1'h0;
      end
      if (!hs_a && hs_q) hs_len <= hs_cnt;
      if (!vs_a && vs_q) vs_len <= vs_cnt;
      if (vs_a && !vs_q) begin
        vs_start  <= pix;
        frame_len <= fcnt;
        fcnt      <= 16'h0001;
        act_lines <= lines;
        lines     <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// testbench for the tft panel timing core: registers and panel timing
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tft_timing_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        mclk = 1'h0;
  logic        rst  = 1'h1;
  reg_req_s    bus  = '0;
  logic [7:0]  rdata;
  panel_s      panel;
  logic        pixel_16bpp;
  logic        host_bus_16;
  logic        inv  = 1'h0;
  logic        pol  = 1'h0;
  logic [15:0] clk_per, line_len, de_len, hs_start, hs_len, vs_start, vs_len;
  logic [15:0] frame_len, act_lines;
  int          num_errors = 0;
  int          check_count = 0;
  // offsets and writable masks of eight of the configuration registers, 0x10 to 0x1A
  localparam logic [7:0] OFS [8] = '{8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A};
  localparam logic [7:0] MSK [8] = '{8'h0F, 8'h7F, 8'h8F, 8'h1F, 8'h1F, 8'h9F, 8'hFF, 8'h01};

  always #20 mclk = ~mclk;

  tft_panel_timing_config dut_u (
    .mclk        (mclk),
    .rst         (rst),
    .bus         (bus),
    .rdata       (rdata),
    .panel       (panel),
    .pixel_16bpp (pixel_16bpp),
    .host_bus_16 (host_bus_16)
  );

  panel_model model_u (
    .mclk(mclk), .rst(rst), .panel(panel), .inv(inv), .pol(pol),
    .clk_per(clk_per), .line_len(line_len), .de_len(de_len), .hs_start(hs_start),
    .hs_len(hs_len), .vs_start(vs_start), .vs_len(vs_len), .frame_len(frame_len),
    .act_lines(act_lines)
  );

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge mclk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe, then drop to zero
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge mclk);
    bus <= '0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
    @(posedge mclk);
    #1;
    chk({8'h00, rdata}, 16'h0000);
  endtask

  // program a geometry, let three frames pass, compare the measurements
  task automatic run_cfg(input logic [1:0] code, input logic p, input logic [3:0] fine,
                         input logic iv);
    logic [15:0] t;
    t = 16'h0032 + {12'h000, fine};
    pol <= p;
    inv <= iv;
    wr(8'h04, {iv, 5'h00, code});
    wr(8'h14, 8'h01);
    wr(8'h15, {p, 3'h0, fine});
    wr(8'h16, 8'h03);
    wr(8'h17, 8'h01);
    wr(8'h18, {p, 7'h01});
    wr(8'h19, 8'h02);
    wr(8'h1B, 8'h03);
    wr(8'h1F, {p, 7'h02});
    repeat (21 * t * (1 << code)) @(posedge mclk);
    #1;
    chk(clk_per, 16'h0001 << code);
    chk(de_len, 16'h0010);
    chk(line_len, t);
    chk(hs_start, 16'h0020);
    chk(hs_len, 16'h0010);
    chk(act_lines, 16'h0003);
    chk(vs_start, t << 1);
    chk(vs_len, 16'h0003 * t);
    chk(frame_len, 16'h0007 * t);
  endtask

  task automatic summarize;
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    #1;
    chk({12'h000, panel}, 16'h0006);
    // first free-running pixel is active; undivided clock parks high
    @(posedge mclk);
    #1;
    chk({12'h000, panel}, 16'h000F);
    rd(8'h11, 8'h01);
    // reset values, then reserved bits dropped; zero restored at once
    for (int i = 0; i < 8; i++) begin
      rd(OFS[i], 8'h00);
      wr(OFS[i], 8'hFF);
      rd(OFS[i], MSK[i]);
      wr(OFS[i], 8'h00);
    end
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h00);
    // every depth and bus-width code
    for (int v = 0; v < 16; v++) begin
      wr(8'h10, v[7:0]);
      repeat (2) @(posedge mclk);
      #1;
      chk({14'h0000, pixel_16bpp, host_bus_16}, {14'h0000, v[3], v[1]});
    end
    // undivided mode parks the pin at a level set by the inversion bit
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, {k[0], 7'h00});
      repeat (3) @(posedge mclk);
      #1;
      chk({15'h0000, panel.pclk}, {15'h0000, ~k[0]});
    end
    run_cfg(2'h1, 1'h0, 4'h5, 1'h0);
    run_cfg(2'h2, 1'h1, 4'h0, 1'h1);
    run_cfg(2'h3, 1'h0, 4'hF, 1'h0);
    summarize();
  end

  // watchdog, well beyond the roughly 17600 cycles the sequence needs
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
